// [src/pipl_pkg.sv]
// Constants and types shared by the inset layout engine
`default_nettype none

package pipl_pkg;

    // ------------------------------------------------------------
    // Register map (subaddresses of the serial control port)
    // ------------------------------------------------------------
    localparam logic [7:0] SA_LAYOUT_CONTROL         = 8'h20;
    localparam logic [7:0] SA_MAIN_ROW_FIRST_OFFSET  = 8'h21;
    localparam logic [7:0] SA_MAIN_ROW_REPEAT_COUNT  = 8'h22;
    localparam logic [7:0] SA_MAIN_PICTURE_WIDTH     = 8'h23;
    localparam logic [7:0] SA_MAIN_PICTURE_HEIGHT    = 8'h24;
    localparam logic [7:0] SA_MAIN_ROW0_COL_SPACING  = 8'h25;
    localparam logic [7:0] SA_MAIN_ROW_SPACING       = 8'h29;
    localparam logic [7:0] SA_SUB_ROW_FIRST_OFFSET   = 8'h2A;
    localparam logic [7:0] SA_SUB_ROW_REPEAT_COUNT   = 8'h2B;
    localparam logic [7:0] SA_SUB_PICTURE_WIDTH      = 8'h2C;
    localparam logic [7:0] SA_SUB_PICTURE_HEIGHT     = 8'h2D;
    localparam logic [7:0] SA_SUB_ROW0_COL_SPACING   = 8'h2E;
    localparam logic [7:0] SA_SUB_ROW_SPACING        = 8'h32;

    // Register array indexing: index = subaddress - first subaddress
    localparam int NUM_REGS   = 19;
    localparam int IDX_CTL    = 0;
    localparam int IDX_MAIN   = 1;
    localparam int IDX_SUB    = 10;
    localparam int OFS_FIRST  = 0;
    localparam int OFS_REP    = 1;
    localparam int OFS_WIDTH  = 2;
    localparam int OFS_HEIGHT = 3;
    localparam int OFS_COLSP  = 4;
    localparam int OFS_LINESP = 8;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Layout control fields
    localparam int CTL_ORDER_BIT    = 7;
    localparam int CTL_MAIN_REP_LSB = 2;
    localparam int CTL_SUB_REP_LSB  = 0;

    // Geometry
    localparam int POS_W           = 12;
    localparam int PIX_STEP_SHIFT  = 2;
    localparam int MAX_ROWS        = 4;
    localparam int GRID_POINTS     = 4;

    // Serial port slave address, arbitrary value
    localparam logic [6:0] I2C_DEV_ADDR = 7'h2A;

    typedef enum logic [1:0] {
        LAY_NONE = 2'b00,
        LAY_MAIN = 2'b01,
        LAY_SUB  = 2'b10
    } pipl_layer_t;

    typedef enum logic [1:0] {
        I2C_IDLE = 2'b00,
        I2C_DEV  = 2'b01,
        I2C_SUB  = 2'b10,
        I2C_DATA = 2'b11
    } pipl_i2c_st_t;

endpackage : pipl_pkg

`default_nettype wire

// [src/pipl_i2c_wr.sv]
// Write-only serial control port slave with auto-incrementing subaddress
`default_nettype none

module pipl_i2c_wr
    import pipl_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Serial bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Register write strobe
    output logic            wr_stb,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data
);

    pipl_i2c_st_t st_q;
    logic         scl_q;
    logic         sda_q;
    logic [3:0]   cnt_q;
    logic [7:0]   shift_q;
    logic [7:0]   sub_q;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_c;
    logic         stop_c;

    // ------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;

    // Previous pin levels
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Open-drain data pin only ever pulls low
    always_ff @(posedge core_clk) begin
        sda_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Byte framing, acknowledge and register writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q    <= I2C_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            sub_q   <= 8'h00;
            sda_oe  <= 1'b0;
            wr_stb  <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start_c) begin
                st_q   <= I2C_DEV;
                cnt_q  <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                st_q   <= I2C_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise && st_q != I2C_IDLE) begin
                if (cnt_q == 4'h8) begin
                    cnt_q <= 4'h0;
                end else begin
                    shift_q <= {shift_q[6:0], sda_i};
                    cnt_q   <= cnt_q + 4'h1;
                end
            end else if (scl_fall && cnt_q == 4'h8) begin
                // Eighth bit done: decide on acknowledge
                case (st_q)
                    I2C_DEV: begin
                        if (shift_q == {I2C_DEV_ADDR, 1'b0}) begin
                            st_q   <= I2C_SUB;
                            sda_oe <= 1'b1;
                        end else begin
                            st_q <= I2C_IDLE;
                        end
                    end
                    I2C_SUB: begin
                        sub_q  <= shift_q;
                        st_q   <= I2C_DATA;
                        sda_oe <= 1'b1;
                    end
                    I2C_DATA: begin
                        wr_stb  <= 1'b1;
                        wr_addr <= sub_q;
                        wr_data <= shift_q;
                        sub_q   <= sub_q + 8'h01;
                        sda_oe  <= 1'b1;
                    end
                    default: begin
                        st_q <= I2C_IDLE;
                    end
                endcase
            end else if (scl_fall && cnt_q == 4'h0) begin
                sda_oe <= 1'b0; // Release after acknowledge clock
            end
        end
    end

endmodule : pipl_i2c_wr

`default_nettype wire

// [src/pipl_channel_grid.sv]
// Per-channel inset placement: rows, grid points, repeats, sizes
`default_nettype none

module pipl_channel_grid
    import pipl_pkg::*;
(
    // Channel settings, stable over a field
    input  wire logic              chan_on,
    input  wire logic [1:0]        row_repeat,
    input  wire logic [7:0]        first_grid_point,
    input  wire logic [7:0]        column_repeat,
    input  wire logic [7:0]        width,
    input  wire logic [7:0]        height,
    input  wire logic [7:0]        line_spacing,
    input  wire logic [31:0]       column_spacing,
    // Raster position
    input  wire logic [POS_W-1:0]  pos_x,
    input  wire logic [POS_W-1:0]  pos_y,
    // Placement result
    output logic                   hit,
    output logic [1:0]             hit_row,
    output logic [1:0]             hit_col
);

    logic [POS_W-1:0] pic_w;
    logic [POS_W-1:0] pic_h;
    logic [POS_W-1:0] row_y;
    logic [POS_W-1:0] pic_x;
    logic [2:0]       first;
    logic [2:0]       last;

    // Offset of grid point or row idx for a given step
    function automatic logic [POS_W-1:0] span(input logic [1:0] idx, input logic [7:0] step);
        span = POS_W'(idx) * POS_W'(step);
    endfunction : span

    // Step plus one keeps the 4 pixel and 1 line minimum
    assign pic_w = (POS_W'(width) + POS_W'(1)) << PIX_STEP_SHIFT;
    assign pic_h = POS_W'(height) + POS_W'(1);

    // ------------------------------------------------------------
    // Scan rows and grid points; later match overwrites earlier
    // ------------------------------------------------------------
    always_comb begin
        hit     = 1'b0;
        hit_row = 2'h0;
        hit_col = 2'h0;
        row_y   = '0;
        pic_x   = '0;
        first   = 3'h0;
        last    = 3'h0;
        for (int r = 0; r < MAX_ROWS; r++) begin
            row_y = span(2'(r), line_spacing);
            first = {1'b0, first_grid_point[2*r +: 2]};
            last  = first + {1'b0, column_repeat[2*r +: 2]};
            // Row 0 is always shown while chan_on is set; repeat count adds rows
            if (chan_on && 2'(r) <= row_repeat && pos_y >= row_y
                && pos_y < row_y + pic_h) begin
                for (int c = 0; c < GRID_POINTS; c++) begin
                    pic_x = span(2'(c), column_spacing[8*r +: 8]) << PIX_STEP_SHIFT;
                    if (3'(c) >= first && 3'(c) <= last
                        && pos_x >= pic_x && pos_x < pic_x + pic_w) begin
                        hit     = 1'b1;
                        hit_row = 2'(r);
                        hit_col = 2'(c);
                    end
                end
            end
        end
    end

endmodule : pipl_channel_grid

`default_nettype wire

// [src/pipl_layout_top.sv]
// Inset layout engine: register file, field shadow, raster and stacking
//
// Overview of operation
// - Stack bit 0 puts sub insets on top; 1 puts main insets on top.
// - Row repeat field adds rows; an enabled channel always shows one row.
// - Each row has grid points 0 to 3 spaced by its column spacing.
// - A row's first shown picture sits at its first grid point field.
// - Column repeat field adds pictures after the first, on grid points.
// - Picture width is the 8-bit field in steps of 4 pixels.
// - Picture height is the 8-bit field in steps of 1 line.
// - Grid points in a row are spaced by its field times 4 pixels.
// - Rows are spaced by the channel line spacing field in lines.
// - Pictures are at least 4 pixels wide and 1 line high.
// - At most four rows per channel and four pictures per row.
// - Main and sub have separate identical controls, shown together.
`default_nettype none

module pipl_layout_top
    import pipl_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Serial control port
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Channel on/off controls
    input  wire logic       main_on,
    input  wire logic       sub_on,
    // Display raster timing
    input  wire logic       pix_en,
    input  wire logic       line_start,
    input  wire logic       field_start,
    // Inset overlay result
    output pipl_layer_t     layer_q,
    output logic [1:0]      pic_row_q,
    output logic [1:0]      pic_col_q
);

    logic [7:0]       regs_q [NUM_REGS];
    logic [7:0]       shd_q  [NUM_REGS];
    logic             main_on_q;
    logic             sub_on_q;
    logic [POS_W-1:0] x_q;
    logic [POS_W-1:0] y_q;
    logic             wr_stb;
    logic [7:0]       wr_addr;
    logic [7:0]       wr_data;
    logic             m_hit;
    logic [1:0]       m_row;
    logic [1:0]       m_col;
    logic             s_hit;
    logic [1:0]       s_row;
    logic [1:0]       s_col;
    logic             stack_main;

    // Subaddress lies within the layout register block
    function automatic logic in_layout(input logic [7:0] addr);
        in_layout = (addr >= SA_LAYOUT_CONTROL) && (addr <= SA_SUB_ROW_SPACING);
    endfunction : in_layout

    // Register index of a layout subaddress
    function automatic logic [4:0] reg_idx(input logic [7:0] addr);
        reg_idx = 5'(addr - SA_LAYOUT_CONTROL);
    endfunction : reg_idx

    // ------------------------------------------------------------
    // Serial control port
    // ------------------------------------------------------------
    pipl_i2c_wr u_i2c (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .wr_stb   (wr_stb),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data)
    );

    // ------------------------------------------------------------
    // Write-only register file
    // ------------------------------------------------------------
    // Writes outside the layout block are ignored here
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (wr_stb && in_layout(wr_addr)) begin
            regs_q[reg_idx(wr_addr)] <= wr_data;
        end
    end

    // Field-start shadow so a half-written layout is never shown
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                shd_q[i] <= REG_RESET;
            end
            main_on_q <= 1'b0;
            sub_on_q  <= 1'b0;
        end else if (field_start) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                shd_q[i] <= regs_q[i];
            end
            main_on_q <= main_on;
            sub_on_q  <= sub_on;
        end
    end

    // ------------------------------------------------------------
    // Raster position counters
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            x_q <= '0;
            y_q <= '0;
        end else if (field_start) begin
            x_q <= '0;
            y_q <= '0;
        end else if (line_start) begin
            x_q <= '0;
            y_q <= y_q + POS_W'(1);
        end else if (pix_en) begin
            x_q <= x_q + POS_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Two identical, independent channel placers
    // ------------------------------------------------------------
    pipl_channel_grid u_main (
        .chan_on          (main_on_q),
        .row_repeat       (shd_q[IDX_CTL][CTL_MAIN_REP_LSB +: 2]),
        .first_grid_point (shd_q[IDX_MAIN + OFS_FIRST]),
        .column_repeat    (shd_q[IDX_MAIN + OFS_REP]),
        .width            (shd_q[IDX_MAIN + OFS_WIDTH]),
        .height           (shd_q[IDX_MAIN + OFS_HEIGHT]),
        .line_spacing     (shd_q[IDX_MAIN + OFS_LINESP]),
        .column_spacing   ({shd_q[IDX_MAIN + OFS_COLSP + 3], shd_q[IDX_MAIN + OFS_COLSP + 2],
                            shd_q[IDX_MAIN + OFS_COLSP + 1], shd_q[IDX_MAIN + OFS_COLSP]}),
        .pos_x            (x_q),
        .pos_y            (y_q),
        .hit              (m_hit),
        .hit_row          (m_row),
        .hit_col          (m_col)
    );

    pipl_channel_grid u_sub (
        .chan_on          (sub_on_q),
        .row_repeat       (shd_q[IDX_CTL][CTL_SUB_REP_LSB +: 2]),
        .first_grid_point (shd_q[IDX_SUB + OFS_FIRST]),
        .column_repeat    (shd_q[IDX_SUB + OFS_REP]),
        .width            (shd_q[IDX_SUB + OFS_WIDTH]),
        .height           (shd_q[IDX_SUB + OFS_HEIGHT]),
        .line_spacing     (shd_q[IDX_SUB + OFS_LINESP]),
        .column_spacing   ({shd_q[IDX_SUB + OFS_COLSP + 3], shd_q[IDX_SUB + OFS_COLSP + 2],
                            shd_q[IDX_SUB + OFS_COLSP + 1], shd_q[IDX_SUB + OFS_COLSP]}),
        .pos_x            (x_q),
        .pos_y            (y_q),
        .hit              (s_hit),
        .hit_row          (s_row),
        .hit_col          (s_col)
    );

    // ------------------------------------------------------------
    // Channel stacking and registered overlay output
    // ------------------------------------------------------------
    assign stack_main = shd_q[IDX_CTL][CTL_ORDER_BIT];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            layer_q   <= LAY_NONE;
            pic_row_q <= 2'h0;
            pic_col_q <= 2'h0;
        end else if (pix_en) begin
            if (m_hit && (stack_main || !s_hit)) begin
                layer_q   <= LAY_MAIN;
                pic_row_q <= m_row;
                pic_col_q <= m_col;
            end else if (s_hit) begin
                layer_q   <= LAY_SUB;
                pic_row_q <= s_row;
                pic_col_q <= s_col;
            end else begin
                layer_q   <= LAY_NONE;
                pic_row_q <= 2'h0;
                pic_col_q <= 2'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [POS_W-1:0] chk_main_w;
    logic [POS_W-1:0] chk_main_h;
    logic [2:0]       chk_first;
    logic [2:0]       chk_last;
    logic             lay_new_q;

    assign chk_main_w = (POS_W'(shd_q[IDX_MAIN + OFS_WIDTH]) + POS_W'(1)) << PIX_STEP_SHIFT;
    assign chk_main_h = POS_W'(shd_q[IDX_MAIN + OFS_HEIGHT]) + POS_W'(1);
    assign chk_first  = {1'b0, shd_q[IDX_MAIN + OFS_FIRST][2*pic_row_q +: 2]};
    assign chk_last   = chk_first + {1'b0, shd_q[IDX_MAIN + OFS_REP][2*pic_row_q +: 2]};

    // Overlay stale until first pixel of a field
    always_ff @(posedge core_clk) begin
        if (!rst_b || field_start) begin
            lay_new_q <= 1'b0;
        end else if (pix_en) begin
            lay_new_q <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence both_hit_s;
        pix_en && m_hit && s_hit && !field_start;
    endsequence

    sequence main_corner_s;
        pix_en && main_on_q && !s_hit && !field_start && !line_start
            && shd_q[IDX_MAIN + OFS_FIRST][1:0] == 2'h0 && x_q < chk_main_w && y_q < chk_main_h
            && (y_q < POS_W'(shd_q[IDX_MAIN + OFS_LINESP])
                || shd_q[IDX_CTL][CTL_MAIN_REP_LSB +: 2] == 2'h0);
    endsequence

    AST_CHANNEL_STACK_ORDER_SUB: assert property (
        both_hit_s ##0 !stack_main |=> layer_q == LAY_SUB)
        else $error("sub inset not on top with stack bit clear");

    AST_CHANNEL_STACK_ORDER_MAIN: assert property (
        both_hit_s ##0 stack_main |=> layer_q == LAY_MAIN)
        else $error("main inset not on top with stack bit set");

    AST_ONE_ROW: assert property (
        main_corner_s |=> layer_q == LAY_MAIN && pic_row_q == 2'h0)
        else $error("first main picture missing at row 0 corner");

    AST_ROWS_MAX: assert property (
        layer_q == LAY_MAIN && lay_new_q
        |-> pic_row_q <= shd_q[IDX_CTL][CTL_MAIN_REP_LSB +: 2])
        else $error("main picture shown beyond repeated row count");

    AST_FIRST_POINT: assert property (
        layer_q == LAY_MAIN && lay_new_q
        |-> {1'b0, pic_col_q} >= chk_first)
        else $error("main picture left of row first grid point");

    AST_REPEAT_LIMIT: assert property (
        layer_q == LAY_MAIN && lay_new_q |-> {1'b0, pic_col_q} <= chk_last)
        else $error("main picture beyond row repeat count");

    AST_SHADOW_HOLD: assert property (
        !field_start |=> $stable(shd_q[IDX_MAIN + OFS_WIDTH]) && $stable(shd_q[IDX_CTL]))
        else $error("layout settings changed outside field start");

    AST_SHADOW_LOAD: assert property (
        field_start |=> shd_q[IDX_SUB + OFS_HEIGHT] == $past(regs_q[IDX_SUB + OFS_HEIGHT]))
        else $error("layout settings not taken at field start");

    AST_REG_SEPARATE: assert property (
        wr_stb && wr_addr == SA_SUB_PICTURE_WIDTH
        |=> regs_q[IDX_SUB + OFS_WIDTH] == $past(wr_data)
            && $stable(regs_q[IDX_MAIN + OFS_WIDTH]))
        else $error("sub width write not separate from main");

    // Off channels stay hidden; on bits load at field start
    AST_MAIN_OFF: assert property (
        pix_en && !main_on_q
        |=> layer_q != LAY_MAIN)
        else $error("main inset shown while off");

    AST_SUB_OFF: assert property (
        pix_en && !sub_on_q
        |=> layer_q != LAY_SUB)
        else $error("sub inset shown while off");

    AST_ON_HOLD: assert property (
        !field_start
        |=> $stable(main_on_q) && $stable(sub_on_q))
        else $error("on bits changed mid field");

    AST_ON_LOAD: assert property (
        field_start
        |=> main_on_q == $past(main_on) && sub_on_q == $past(sub_on))
        else $error("on bits not taken at field start");

endmodule : pipl_layout_top

`default_nettype wire

// [verification/pipl_i2c_host.sv]
// Serial control port host model: open-drain write bursts
`default_nettype none

module pipl_i2c_host
    import pipl_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Open-drain pulls, high pulls the wire low
    output logic      scl_low,
    output logic      sda_low,
    // Resolved data wire
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] buf_d [0:NUM_REGS-1];

    // Both lines released at power up
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // One clock phase, three core cycles, changes after the falling edge
    task automatic half();
        repeat (3) @(negedge core_clk);
    endtask : half

    // Byte MSB first, then the acknowledge clock; ack read while clock is high
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            half();
            scl_low = 1'b0;
            half();
            scl_low = 1'b1;
        end
        sda_low = 1'b0;
        half();
        scl_low = 1'b0;
        half();
        ack = ~sda;
        scl_low = 1'b1;
    endtask : put_byte

    // Start, address with write bit, subaddress, n data bytes, stop
    task automatic wr_burst(input logic [6:0] dev, input int n, output logic ack);
        logic a;
        sda_low = 1'b1;
        half();
        scl_low = 1'b1;
        half();
        put_byte({dev, 1'b0}, ack);
        put_byte(SA_LAYOUT_CONTROL, a);
        ack &= a;
        for (int k = 0; k < n; k++) begin
            put_byte(buf_d[k], a);
            ack &= a;
        end
        sda_low = 1'b1;
        half();
        scl_low = 1'b0;
        half();
        sda_low = 1'b0;
        half();
    endtask : wr_burst
endmodule : pipl_i2c_host

`default_nettype wire

// [verification/pipl_layout_top_test.sv]
// Self-checking bench of the inset layout engine
`default_nettype none

module pipl_layout_top_test
    import pipl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int NX = 48;
    localparam int NY = 20;

    logic        core_clk, rst_b, main_on, sub_on, pix_en, line_start, field_start;
    logic        scl_low, sda_low, sda_o, sda_oe, ack, good;
    pipl_layer_t layer_q;
    logic [1:0]  pic_row_q, pic_col_q;
    logic [7:0]  pend [0:NUM_REGS-1];
    logic [7:0]  cur [0:NUM_REGS-1];
    logic [1:0]  cur_on;
    logic [31:0] rnd;
    int          error_cnt, n_tests, y;
    wire         scl = ~scl_low;
    wire         sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;

    pipl_i2c_host host (.core_clk(core_clk), .scl_low(scl_low), .sda_low(sda_low), .sda(sda));

    pipl_layout_top uut (
        .core_clk(core_clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .main_on(main_on), .sub_on(sub_on), .pix_en(pix_en),
        .line_start(line_start), .field_start(field_start), .layer_q(layer_q),
        .pic_row_q(pic_row_q), .pic_col_q(pic_col_q));

    // ------------------------------------------------------------
    // Expectation functions
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Covering picture of one channel as {hit, row, col}; later rows/columns win
    function automatic logic [4:0] chan(input int b, input int rep, input int x);
        logic [4:0] res;
        int top, lft, f, last;
        res = 5'h00;
        for (int r = 0; r <= rep; r++) begin
            top = r * cur[b+OFS_LINESP];
            f = (cur[b+OFS_FIRST] >> (2 * r)) & 3;
            last = f + ((cur[b+OFS_REP] >> (2 * r)) & 3);
            if (last > 3)
                last = 3;
            if (y >= top && y < top + cur[b+OFS_HEIGHT] + 1)
                for (int c = f; c <= last; c++) begin
                    lft = c * cur[b+OFS_COLSP+r] * 4;
                    if (x >= lft && x < lft + (cur[b+OFS_WIDTH] + 1) * 4)
                        res = {1'b1, r[1:0], c[1:0]};
                end
        end
        return res;
    endfunction : chan

    function automatic logic [5:0] expect_pix(input int x);
        logic [4:0] m, s;
        m = cur_on[0] ? chan(IDX_MAIN, cur[IDX_CTL][CTL_MAIN_REP_LSB+:2], x) : 5'h00;
        s = cur_on[1] ? chan(IDX_SUB, cur[IDX_CTL][CTL_SUB_REP_LSB+:2], x) : 5'h00;
        if (s[4] && !(m[4] && cur[IDX_CTL][CTL_ORDER_BIT]))
            return {LAY_SUB, s[3:0]};
        if (m[4])
            return {LAY_MAIN, m[3:0]};
        return {LAY_NONE, 4'h0};
    endfunction : expect_pix

    // ------------------------------------------------------------
    // Compare, drive and closing tasks
    // ------------------------------------------------------------
    task automatic cmp_pix(input int x);
        logic [5:0] e;
        e = expect_pix(x);
        n_tests++;
        if ({layer_q, pic_row_q, pic_col_q} !== e) begin
            error_cnt++;
            $display("unexpected at %0t: pixel %0d,%0d got %h", $time, x, y,
                     {layer_q, pic_row_q, pic_col_q});
        end
    endtask : cmp_pix

    task automatic cmp_ack(input logic got, input logic want);
        n_tests++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: acknowledge %b", $time, got);
        end
    endtask : cmp_ack

    // One raster line with back-to-back pixels, each result checked next cycle
    task automatic line(input logic ls);
        if (ls) begin
            @(negedge core_clk);
            line_start = 1'b1;
            y++;
        end
        for (int x = 0; x <= NX; x++) begin
            @(negedge core_clk);
            field_start = 1'b0;
            line_start = 1'b0;
            if (x > 0)
                cmp_pix(x - 1);
            pix_en = (x < NX);
        end
    endtask : line

    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        $display("unexpected at %0t: timeout", $time);
        stop_test();
    end

    initial begin
        {rst_b, main_on, sub_on, pix_en, line_start, field_start} = 6'h00;
        {error_cnt, n_tests, y} = 0;
        rnd = 32'hFBEA;
        cur = '{default: 8'h00};
        pend = cur;
        cur_on = 2'b00;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 7; i++) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                rnd = lfsr(rnd);
                host.buf_d[k] = (i == 0) ? 8'h00 : rnd[7:0];
            end
            host.buf_d[IDX_CTL] &= (i == 1) ? 8'h0F : 8'h8F;
            for (int b = IDX_MAIN; b <= IDX_SUB; b += IDX_SUB - IDX_MAIN) begin
                host.buf_d[b+OFS_WIDTH] &= 8'h07;
                host.buf_d[b+OFS_HEIGHT] &= 8'h03;
                host.buf_d[b+OFS_LINESP] &= 8'h07;
                for (int r = 0; r < MAX_ROWS; r++)
                    host.buf_d[b+OFS_COLSP+r] &= 8'h03;
                if (i == 1)
                    host.buf_d[b+OFS_REP] = 8'hFF;
            end
            good = (i != 4);
            host.wr_burst(good ? I2C_DEV_ADDR : I2C_DEV_ADDR ^ 7'h01, NUM_REGS, ack);
            cmp_ack(ack, good);
            if (good)
                pend = host.buf_d;
            line(1'b1);
            @(negedge core_clk);
            field_start = 1'b1;
            main_on = rnd[8] | (i < 2);
            sub_on = rnd[9] | (i < 2);
            cur = pend;
            cur_on = {sub_on, main_on};
            y = 0;
            @(negedge core_clk);
            field_start = 1'b0;
            main_on = ~main_on;
            sub_on = ~sub_on;
            line(1'b0);
            for (int l = 1; l < NY; l++)
                line(1'b1);
        end
        stop_test();
    end
endmodule : pipl_layout_top_test

`default_nettype wire
